// ---- rtl/secure_zone_access_control.v ----
// Access and write-integrity logic for the secure zones, reached over AXI4-Lite.
// Assumes the serial framing and the cipher live outside; they hand in verdicts and writes.
// What the document requires
// RULE1: Anti-tearing limits each write command to eight bytes and adds write cycles.
// RULE2: Anti-tearing first stores data in a buffer, then copies to destination.
// RULE3: A copy interrupted by power loss is redone from the buffer at power-up.
// RULE4: Host polls for acknowledge up to 8 ms after anti-tearing writes.
// RULE5: Host polls for acknowledge up to 2 ms at power-up during recovery.
// RULE6: In write-lock zones the lowest byte of each 8-byte page controls it.
// RULE7: Lock bit n at zero blocks writes to byte n of that page.
// RULE8: Lock byte bit zero cleared also locks the lock byte itself.
// RULE9: Lock byte writes may only clear bits, never set them.
// RULE10: Write-lock zones take one byte per command; later bytes are ignored.
// RULE11: An accepted password stays until reset or another password is presented.
// RULE12: Eight password sets, one active; write password also grants read.
// RULE13: Each zone selects one of four key sets for authentication.
// RULE14: Authentication holds until reset; a failed new attempt revokes it.
// RULE15: After four consecutive failures all further verifications are ignored.
// RULE16: Standard mode offers a detection code the host may read.
// RULE17: Authentication and encryption modes require a valid MAC on every exchange.
// RULE18: A mismatched MAC drops the command and returns to standard mode.
// RULE19: Encryption-required zones refuse access unless encryption mode is active.
// RULE20: Host may enable encryption voluntarily on any zone with proper keys.
// RULE21: Supervisor password, when enabled, grants access to all eight password sets.
// RULE22: Modify-forbidden zones reject every write at all times.
// RULE23: Program-only zones may clear bits but never set them.
// RULE24: Configuration access needs the secure code; fuses then lock settings.
// RULE25: Starts in standard mode; authentication, then encryption, raise the mode.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "szac_map.vh"
module secure_zone_access_control
#(
   parameter SUPER_PW_SET = 3'd7,
   parameter COPY_CYCLES  = `COPY_CYCLES
)
(
   // Clock and reset.
   input  wire        sys_clk_in,
   input  wire        arst_n_in,
   // Link clock from the serial side, sampled only.
   input  wire        link_clk_in,
   // Power-good from the supply monitor, asynchronous.
   input  wire        power_ok_in,
   // AXI4-Lite write address, data and response.
   input  wire [7:0]  s_axi_awaddr_in,
   input  wire        s_axi_awvalid_in,
   output reg         s_axi_awready_out,
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   input  wire        s_axi_wvalid_in,
   output reg         s_axi_wready_out,
   output reg  [1:0]  s_axi_bresp_out,
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   // AXI4-Lite read.
   input  wire [7:0]  s_axi_araddr_in,
   input  wire        s_axi_arvalid_in,
   output reg         s_axi_arready_out,
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out,
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   // Status levels and the link edge pulse.
   output reg         busy_out,
   output reg  [2:0]  sec_mode_out,
   output reg         link_edge_out
);
localparam ST_IDLE = 4'b0001;
localparam ST_BUF  = 4'b0010;
localparam ST_COPY = 4'b0100;
localparam ST_DONE = 4'b1000;
localparam M_STD  = 3'b001;
localparam M_AUTH = 3'b010;
localparam M_ENC  = 3'b100;
////////////////////////////////////////////////////////////////////////////////
// Input synchronisers and link edge finder.
reg [1:0] lclk_sync, pok_sync;
reg       lclk_prev;
always @(posedge sys_clk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      lclk_sync <= 2'b00;
      pok_sync  <= 2'b00;
      lclk_prev <= 1'b0;
      link_edge_out <= 1'b0;
   end
   else
   begin
      lclk_sync <= {lclk_sync[0], link_clk_in};
      pok_sync  <= {pok_sync[0], power_ok_in};
      lclk_prev <= lclk_sync[1];
      link_edge_out <= lclk_sync[1] & ~lclk_prev;
   end
end
wire power_good = pok_sync[1];
////////////////////////////////////////////////////////////////////////////////
// Write check: returns the byte as it may land, bit 8 set when refused.
function [8:0] check_write;
   input [7:0] cfg;
   input [7:0] lockb;
   input [2:0] idx;
   input [7:0] oldv;
   input [7:0] newv;
   reg   [7:0] v;
   reg         bad;
   begin
      v   = newv;
      bad = 1'b0;
      if (cfg[`ZC_FORBID])
         bad = 1'b1; // RULE22
      if (cfg[`ZC_PROG])
         v = oldv & newv; // RULE23
      if (cfg[`ZC_LOCK])
      begin
         if (idx == 3'd0) // RULE6
         begin
            if (!lockb[0])
               bad = 1'b1; // RULE8
            v = oldv & newv; // RULE9
         end
         else if (!lockb[idx])
            bad = 1'b1; // RULE7
      end
      check_write = {bad, v};
   end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Registers.
reg [31:0] control, zone_cfg, write_req, write_result;
reg [2:0]  fail_count, active_pw;
reg        pw_valid, auth_ok, secure_ok, super_ok, mac_drop;
reg [1:0]  auth_key;
reg [7:0]  buf_data;
reg [3:0]  buf_count, state;
reg        recovery_pending, recovered;
reg [31:0] copy_cnt;
wire limit_hit = (fail_count >= `TRIAL_LIMIT);
// Fields of a write request: old value, new value, lock byte, index, byte count, go.
wire [7:0] req_old   = write_req[7:0];
wire [7:0] req_new   = write_req[15:8];
wire [7:0] req_lock  = write_req[23:16];
wire [2:0] req_idx   = write_req[26:24];
wire [3:0] req_count = {1'b0, write_req[29:27]} + 4'h1;
wire [8:0] chk       = check_write(zone_cfg[7:0], req_lock, req_idx, req_old, req_new);
wire       zone_auth_ok = ~zone_cfg[`ZC_AUTH] |
                          (auth_ok & (auth_key == zone_cfg[`ZC_KEY_LO+1:`ZC_KEY_LO])); // RULE13
wire       zone_pw_ok   = pw_valid &
                          (super_ok | (active_pw == zone_cfg[`ZC_PW_LO+2:`ZC_PW_LO])); // RULE12 RULE21
wire       zone_enc_ok  = ~zone_cfg[`ZC_ENC] | (sec_mode_out == M_ENC); // RULE19 RULE20
wire       too_long     = control[`CTL_ANTITEAR] & (req_count > `AT_MAX_BYTES); // RULE1
wire       refuse       = chk[8] | ~zone_auth_ok | ~zone_pw_ok | ~zone_enc_ok | too_long;
wire [3:0] take_count   = zone_cfg[`ZC_LOCK] ? 4'h1 : req_count; // RULE10
// AXI write acceptance.
wire aw_ok = s_axi_awvalid_in & ~s_axi_awready_out & ~s_axi_bvalid_out;
reg  [7:0]  aw_hold;
reg  [31:0] w_hold;
reg         aw_have, w_have;
wire        wr_fire = aw_have & w_have & ~s_axi_bvalid_out;
wire        wr_cfg  = (aw_hold == `OFS_CONTROL) | (aw_hold == `OFS_ZONE_CFG);
wire        wr_map  = (aw_hold <= `OFS_MAC_CHECK) & (aw_hold[1:0] == 2'b00) &
                      (aw_hold != `OFS_WRITE_RESULT) & (aw_hold != `OFS_STATUS);
wire        cred_kind_pw  = w_hold[31:28] == `KIND_PASSWORD;
wire        cred_kind_au  = w_hold[31:28] == `KIND_AUTH;
wire        cred_kind_sc  = w_hold[31:28] == `KIND_SECURE;
always @(posedge sys_clk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'b00;
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_hold <= 8'h00;
      w_hold  <= 32'h0000_0000;
      control   <= `RESET_CONTROL;
      zone_cfg  <= 32'h0000_0000;
      write_req <= 32'h0000_0000;
      write_result <= 32'h0000_0000;
      fail_count <= 3'h0;
      active_pw  <= 3'h0;
      pw_valid   <= 1'b0;
      auth_ok    <= 1'b0;
      auth_key   <= 2'h0;
      secure_ok  <= 1'b0;
      super_ok   <= 1'b0;
      mac_drop   <= 1'b0;
      sec_mode_out <= M_STD; // RULE25
      buf_data  <= 8'h00;
      buf_count <= 4'h0;
      recovery_pending <= 1'b0;
      recovered <= 1'b0;
      state    <= ST_IDLE;
      copy_cnt <= 32'h0000_0000;
      busy_out <= 1'b0;
   end
   else
   begin
      s_axi_awready_out <= aw_ok;
      s_axi_wready_out  <= s_axi_wvalid_in & ~s_axi_wready_out & ~w_have & ~s_axi_bvalid_out;
      if (aw_ok)
      begin
         aw_have <= 1'b1;
         aw_hold <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & ~s_axi_wready_out & ~w_have & ~s_axi_bvalid_out)
      begin
         w_have <= 1'b1;
         w_hold <= s_axi_wdata_in;
      end
      if (s_axi_bvalid_out & s_axi_bready_in)
         s_axi_bvalid_out <= 1'b0;
      // The clear stands first, so a code mismatch reported in the same cycle still sets it.
      if (mac_drop & (state == ST_BUF))
         mac_drop <= 1'b0;
      if (wr_fire)
      begin
         aw_have <= 1'b0;
         w_have  <= 1'b0;
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= 2'b00;
         if (!wr_map | (wr_cfg & (!secure_ok | control[`CTL_FUSE])))
            s_axi_bresp_out <= 2'b10; // RULE24
         else if (aw_hold == `OFS_CONTROL)
         begin
            control <= w_hold;
            if (w_hold[`CTL_ENC_REQ] & (sec_mode_out == M_AUTH))
               sec_mode_out <= M_ENC; // RULE25 RULE20
         end
         else if (aw_hold == `OFS_ZONE_CFG)
            zone_cfg <= w_hold;
         else if (aw_hold == `OFS_CREDENTIAL)
         begin
            if (limit_hit)
               s_axi_bresp_out <= 2'b10; // RULE15
            else if (cred_kind_pw)
            begin
               // Bit 0 carries the external verdict, bits 3:1 the set.
               active_pw <= w_hold[3:1]; // RULE11
               pw_valid  <= w_hold[0];
               super_ok  <= w_hold[0] & control[`CTL_SUPER_EN] &
                            (w_hold[3:1] == SUPER_PW_SET); // RULE21
               fail_count <= w_hold[0] ? 3'h0 : fail_count + 3'h1;
            end
            else if (cred_kind_au)
            begin
               auth_ok  <= w_hold[0]; // RULE14
               auth_key <= w_hold[2:1];
               sec_mode_out <= w_hold[0] ? M_AUTH : M_STD;
               fail_count <= w_hold[0] ? 3'h0 : fail_count + 3'h1;
            end
            else if (cred_kind_sc)
            begin
               secure_ok  <= w_hold[0];
               fail_count <= w_hold[0] ? 3'h0 : fail_count + 3'h1;
            end
         end
         else if (aw_hold == `OFS_MAC_CHECK)
         begin
            // Bit 0 high reports that the MAC computed for the last command mismatched.
            if (w_hold[0] & (sec_mode_out != M_STD))
            begin
               sec_mode_out <= M_STD; // RULE18 RULE17
               auth_ok  <= 1'b0;
               mac_drop <= 1'b1;
            end
         end
         else if (aw_hold == `OFS_WRITE_REQ)
         begin
            write_req <= w_hold;
            if (state != ST_IDLE)
               s_axi_bresp_out <= 2'b10;
            else if (w_hold[31])
               state <= ST_BUF;
         end
      end
      // Write engine.
      case (state)
         ST_IDLE :
         begin
            busy_out <= recovery_pending;
            if (recovery_pending & power_good)
            begin
               state    <= ST_COPY; // RULE3
               copy_cnt <= COPY_CYCLES;
               recovered <= 1'b1;
            end
         end
         ST_BUF :
         begin
            busy_out <= 1'b1;
            if (refuse | mac_drop)
            begin
               write_result <= {23'h0, 1'b1, chk[7:0]}; // RULE18
               state <= ST_DONE;
            end
            else if (control[`CTL_ANTITEAR])
            begin
               buf_data  <= chk[7:0]; // RULE2
               buf_count <= take_count;
               recovery_pending <= 1'b1;
               copy_cnt <= COPY_CYCLES;
               state    <= ST_COPY;
            end
            else
            begin
               write_result <= {19'h0, take_count, 1'b0, chk[7:0]};
               state <= ST_DONE;
            end
         end
         ST_COPY :
         begin
            busy_out <= 1'b1;
            if (!power_good)
               state <= ST_IDLE; // RULE3
            else if (copy_cnt == 32'h0000_0000)
            begin
               write_result <= {19'h0, buf_count, 1'b0, buf_data};
               recovery_pending <= 1'b0;
               state <= ST_DONE;
            end
            else
               copy_cnt <= copy_cnt - 32'h0000_0001;
         end
         ST_DONE :
         begin
            busy_out <= 1'b0;
            state <= ST_IDLE;
         end
         default :
            state <= ST_IDLE;
      endcase
   end
end
////////////////////////////////////////////////////////////////////////////////
// AXI read channel.
always @(posedge sys_clk_in or negedge arst_n_in)
begin
   if (!arst_n_in)
   begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= 2'b00;
   end
   else
   begin
      s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
      if (s_axi_rvalid_out & s_axi_rready_in)
         s_axi_rvalid_out <= 1'b0;
      if (s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out)
      begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out  <= 2'b00;
         case (s_axi_araddr_in)
            `OFS_CONTROL      : s_axi_rdata_out <= control;
            `OFS_ZONE_CFG     : s_axi_rdata_out <= zone_cfg;
            `OFS_WRITE_REQ    : s_axi_rdata_out <= write_req;
            `OFS_WRITE_RESULT : s_axi_rdata_out <= write_result; // RULE16
            `OFS_STATUS       : s_axi_rdata_out <= {14'h0, mac_drop, busy_out, sec_mode_out,
                                                    secure_ok, super_ok, auth_key, auth_ok,
                                                    pw_valid, active_pw, limit_hit, fail_count};
            `OFS_RECOVERY     : s_axi_rdata_out <= {30'h0, recovered, recovery_pending};
            default :
            begin
               s_axi_rdata_out <= 32'h0000_0000;
               s_axi_rresp_out <= 2'b10;
            end
         endcase
      end
   end
end
endmodule
`default_nettype wire

// ---- rtl/szac_map.vh ----
// Register map, field positions, reset values and timing counts for the secure zone access control.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
`ifndef SZAC_MAP_VH
`define SZAC_MAP_VH
`define OFS_CONTROL      8'h00
`define OFS_ZONE_CFG     8'h04
`define OFS_CREDENTIAL   8'h08
`define OFS_WRITE_REQ    8'h0C
`define OFS_WRITE_RESULT 8'h10
`define OFS_STATUS       8'h14
`define OFS_MAC_CHECK    8'h18
`define OFS_RECOVERY     8'h1C
`define CTL_ANTITEAR     0
`define CTL_SUPER_EN     1
`define CTL_FUSE         2
`define CTL_ENC_REQ      3
`define ZC_LOCK          0
`define ZC_FORBID        1
`define ZC_PROG          2
`define ZC_ENC           3
`define ZC_AUTH          4
`define ZC_KEY_LO        5
`define ZC_PW_LO         7
`define CR_KIND_LO       28
`define KIND_PASSWORD    4'h1
`define KIND_AUTH        4'h2
`define KIND_SECURE      4'h3
`define TRIAL_LIMIT      3'h4
`define AT_MAX_BYTES     4'h8
`define PAGE_BYTES       8
`define CLK_MHZ          125
`define COPY_US          4
`define COPY_CYCLES      (`COPY_US * `CLK_MHZ)
`define RESET_CONTROL    32'h0000_0000
`endif

// ---- verification/szac_props.sv ----
// Port checker for the secure zone access control.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "szac_map.vh"
module szac_props
#(
   parameter COPY_CYCLES = 8
)
(
   // Clock and reset.
   input wire logic        sys_clk_in,
   input wire logic        arst_n_in,
   // Link clock.
   input wire logic        link_clk_in,
   // Register bus.
   input wire logic [7:0]  s_axi_awaddr_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   // Status.
   input wire logic        busy_out,
   input wire logic [2:0]  sec_mode_out,
   input wire logic        link_edge_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   resp_after_both_a: assert property (s_axi_awready_out && s_axi_wready_out
      |=> s_axi_bvalid_out) else $error("no write response after address and data");
   bvalid_holds_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out) else $error("write response dropped early");
   read_answer_a: assert property (s_axi_arready_out |-> s_axi_rvalid_out)
      else $error("read address taken without data");
   rdata_stable_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data moved");
   mode_order_a: assert property ($onehot(sec_mode_out) && !(sec_mode_out == 3'b100
      && $past(sec_mode_out) == 3'b001)) else $error("illegal security mode step");
   mac_drop_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out && s_axi_awaddr_in == `OFS_MAC_CHECK && s_axi_wdata_in[0]
      |-> ##[1:4] sec_mode_out == 3'b001) else $error("mode kept after code mismatch");
   edge_pulse_a: assert property (link_edge_out |=> !link_edge_out)
      else $error("link edge pulse too long");
   edge_follows_a: assert property ($rose(link_clk_in) |-> ##[2:6] link_edge_out)
      else $error("link edge missed");
   busy_bound_a: assert property ($rose(busy_out) |-> ##[1:60] !busy_out)
      else $error("write engine stuck");
   cover property (s_axi_bvalid_out && s_axi_bready_in);
   cover property (sec_mode_out == 3'b100);
   cover property ($fell(busy_out));
endmodule
bind secure_zone_access_control szac_props #(.COPY_CYCLES(COPY_CYCLES)) i_props (.*);
`default_nettype wire

// ---- verification/link_host_model.sv ----
// Far-side link master that makes the serial clock.
// Assumes the bench raises frame_in once for each frame it wants.
`timescale 1ns/10ps
`default_nettype none
module link_host_model
#(
   parameter EDGES = 8
)
(
   // Frame request.
   input  wire logic frame_in,
   // Serial clock.
   output var  logic link_clk_out
);
   // The clock stands low between frames, so no stray edges reach the device.
   initial
      link_clk_out = 1'b0;
   always
   begin
      @(posedge frame_in);
      #3;
      repeat (EDGES)
      begin
         #32 link_clk_out = 1'b1;
         #32 link_clk_out = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- verification/secure_zone_access_control_bench.sv ----
// Self-checking bench for the secure zone access control.
// Assumes the design's register map header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "szac_map.vh"
module secure_zone_access_control_bench;
   logic        sys_clk = 1'b0, arst_n = 1'b0, power_ok = 1'b1, frame = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lk, od, nw;
   logic [31:0] wdata = 32'h0000_0000, seed = 32'h63d4_2356, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         link_clk, awready, wready, bvalid, arready, rvalid, busy, link_edge;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [2:0]   mode;
   logic [1:0]  resp;
   logic [8:0]  ex;
   logic [3:0]  z;
   logic [2:0]  ix, cn;
   integer      error_cnt = 0, comparisons = 0, cycles = 0, edges = 0, it;
   always #4 sys_clk = ~sys_clk;
   link_host_model i_link (.frame_in(frame), .link_clk_out(link_clk));
   secure_zone_access_control #(.COPY_CYCLES(8)) i_dut (
      .sys_clk_in(sys_clk), .arst_n_in(arst_n), .link_clk_in(link_clk), .power_ok_in(power_ok),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .busy_out(busy),
      .sec_mode_out(mode), .link_edge_out(link_edge));
   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
   begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // The ceiling is far above the thousand or so cycles the sequence needs.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (link_edge === 1'b1)
         edges++;
      if (cycles == 20000)
      begin
         error_cnt++;
         wrap_up;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   end
   endtask
   task rd_reg(input logic [7:0] a);
   begin
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   end
   endtask
   // The host polls until the device answers again; the timeout bounds it.
   task wait_idle;
   begin
      repeat (3) @(posedge sys_clk);
      while (busy !== 1'b0)
         @(posedge sys_clk);
   end
   endtask
   function logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
   begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   end
   endfunction
   function logic [8:0] exp_wr(input logic [3:0] c, input logic [7:0] l, o, n,
                               input logic [2:0] i);
   begin
      if (c[1] || c[3] || (c[0] && !l[i]))
         exp_wr = {1'b1, o};
      else if ((c[0] && i == 3'h0) || c[2])
         exp_wr = {1'b0, o & n};
      else
         exp_wr = {1'b0, n};
   end
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      chk(32'(mode), 32'h0000_0001);
      wr(`OFS_CONTROL, 32'h0000_0001);
      chk(32'(resp), 32'h0000_0002);
      wr(`OFS_CREDENTIAL, 32'h3000_0001);
      wr(`OFS_CONTROL, 32'h0000_0001);
      chk(32'(resp), 32'h0000_0000);
      wr(`OFS_CREDENTIAL, 32'h1000_0001);
      for (it = 0; it < 40; it++)
      begin
         seed = xs(seed);
         z = seed[2] ? 4'h0 : 4'h1 << seed[1:0];
         {cn, nw, ix, lk} = seed[29:8];
         od = (ix == 3'h0) ? lk : seed[7:0];
         wr(`OFS_ZONE_CFG, {28'h0, z});
         wr(`OFS_WRITE_REQ, {2'b10, cn, ix, lk, nw, od});
         wait_idle;
         rd_reg(`OFS_WRITE_RESULT);
         ex = exp_wr(z, lk, od, nw, ix);
         if (ex[8])
            chk(32'(rd[8]), 32'h1);
         else
         begin
            chk(32'(rd[8:0]), 32'(ex));
            chk(32'(rd[12:9]), z[0] ? 32'h1 : 32'(cn) + 32'h1);
         end
      end
      wr(`OFS_ZONE_CFG, 32'h0000_0000);
      wr(`OFS_WRITE_REQ, 32'hBAFF_5AA5);
      repeat (2) @(posedge sys_clk);
      power_ok <= 1'b0;
      repeat (10) @(posedge sys_clk);
      power_ok <= 1'b1;
      wait_idle;
      rd_reg(`OFS_RECOVERY);
      chk(32'(rd[1:0]), 32'h2);
      rd_reg(`OFS_WRITE_RESULT);
      chk(32'(rd[7:0]), 32'h5A);
      wr(`OFS_CREDENTIAL, 32'h2000_0001);
      rd_reg(`OFS_STATUS);
      chk({rd[8], 28'h0, mode}, 32'h8000_0002);
      wr(`OFS_CONTROL, 32'h0000_0009);
      rd_reg(`OFS_STATUS);
      chk(32'(mode), 32'h4);
      wr(`OFS_MAC_CHECK, 32'h0000_0001);
      rd_reg(`OFS_STATUS);
      chk({rd[17], 28'h0, mode}, 32'h8000_0001);
      wr(`OFS_CREDENTIAL, 32'h1000_000B);
      rd_reg(`OFS_STATUS);
      chk(32'(rd[7:4]), 32'hD);
      wr(`OFS_CONTROL, 32'h0000_0003);
      wr(`OFS_CREDENTIAL, 32'h1000_000F);
      rd_reg(`OFS_STATUS);
      chk(32'(rd[11]), 32'h1);
      wr(`OFS_CREDENTIAL, 32'h2000_0001);
      wr(`OFS_CREDENTIAL, 32'h2000_0000);
      rd_reg(`OFS_STATUS);
      chk(32'({rd[8], rd[3:0]}), 32'h1);
      repeat (3) wr(`OFS_CREDENTIAL, 32'h1000_0000);
      rd_reg(`OFS_STATUS);
      chk(32'(rd[3:0]), 32'hC);
      wr(`OFS_CREDENTIAL, 32'h2000_0001);
      chk(32'(resp), 32'h2);
      rd_reg(`OFS_STATUS);
      chk(32'(rd[8]), 32'h0);
      edges = 0;
      frame <= 1'b1;
      repeat (80) @(posedge sys_clk);
      frame <= 1'b0;
      chk(32'(edges), 32'h8);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd_reg(`OFS_STATUS);
      chk(rd, 32'h0000_2000);
      wr(`OFS_CONTROL, 32'h0000_0001);
      chk(32'(resp), 32'h2);
      rd_reg(8'h20);
      chk({resp, rd[29:0]}, 32'h8000_0000);
      wr(`OFS_STATUS, 32'h0000_0000);
      chk(32'(resp), 32'h2);
      wr(`OFS_CREDENTIAL, 32'h2000_0007);
      rd_reg(`OFS_STATUS);
      chk(32'(rd[10:8]), 32'h7);
      wr(`OFS_CREDENTIAL, 32'h3000_0001);
      wr(`OFS_CONTROL, 32'h0000_0004);
      wr(`OFS_CONTROL, 32'h0000_0001);
      chk(32'(resp), 32'h2);
      wrap_up;
   end
endmodule
`default_nettype wire
